// ===== design/ccdr_pkg.sv
/*
 * Package for the CCD clock-pattern controller: readout modes, vertical
 * drive levels, timing figures and their cycle counts, line and pixel counts.
 * Assumes a 100 MHz system clock; all cycle counts are derived from that rate.
 */
package ccdr_pkg;

   // Readout mode, chosen per frame
   typedef enum logic [1:0] {
      CCDR_QUAD    = 2'h0,  // Four outputs a, b, c, d
      CCDR_DUAL_AB = 2'h1,  // Outputs a and b
      CCDR_DUAL_AC = 2'h2,  // Outputs a and c
      CCDR_SINGLE  = 2'h3   // Output a only
   } ccdr_mode_t;

   // Vertical pin drive level code for the analog drivers
   typedef enum logic [1:0] {
      CCDR_LVL_LOW  = 2'h0,  // Low level of any phase
      CCDR_LVL_MID  = 2'h1,  // 0 V: high of phases 2-4, mid of phase one
      CCDR_LVL_HIGH = 2'h2   // Third level, phase one only
   } ccdr_lvl_t;

   localparam int CLK_MHZ     = 100;   // System clock rate
   localparam int T_PD_NS     = 1000;  // Photodiode transfer, least
   localparam int T_VSTEP_NS  = 2000;  // One vertical step, least
   localparam int T_HDLY_NS   = 200;   // Vertical to horizontal delay, least
   localparam int T_SUB_NS    = 1000;  // Substrate shutter pulse, least
   localparam int T_PIXPH_NS  = 25;    // Horizontal phase high time, least

   // Least time in ns to whole cycles, rounded up, never below one
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int PD_CYC    = ns2cyc(T_PD_NS);     // Phase one third level
   localparam int VSTEP_CYC = ns2cyc(T_VSTEP_NS);  // Per vertical step
   localparam int HDLY_CYC  = ns2cyc(T_HDLY_NS);   // Before first pixel
   localparam int SUB_CYC   = ns2cyc(T_SUB_NS);    // Shutter pulse width
   localparam int PIX_HALF  = ns2cyc(T_PIXPH_NS);  // Cycles of each half pixel
   localparam int PIX_CYC   = 2 * PIX_HALF;        // Cycles per pixel

   localparam int LINES_HALF = 632;   // Final-line count, half height
   localparam int LINES_FULL = 1264;  // Final-line count, full height
   localparam int PIXS_HALF  = 853;   // Pixel count, half width
   localparam int PIXS_FULL  = 1706;  // Pixel count, full width

   localparam logic [1:0] VSTEP_REST = 2'h3;  // Rest: phases four and one high
   localparam logic [1:0] VSTEP_XFER = 2'h0;  // Step where phase one falls next

   // Modes that read the full column height through the bottom outputs
   function automatic logic full_height(input ccdr_mode_t m);
      return (m == CCDR_DUAL_AB) || (m == CCDR_SINGLE);
   endfunction

   // Modes that read the full row width through one register
   function automatic logic full_width(input ccdr_mode_t m);
      return (m == CCDR_DUAL_AC) || (m == CCDR_SINGLE);
   endfunction

endpackage

// ===== design/ccdr_hline_if.sv
/*
 * Carrier between the frame sequencer and the horizontal line generator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface ccdr_hline_if #(parameter int PIX_W = 11);
   logic             start;  // One-cycle pulse: read one row
   logic [PIX_W-1:0] npix;   // Pixels in the row
   logic             done;   // One-cycle pulse: row finished
   logic             p5;     // Storage phase one pattern
   logic             p6;     // Storage phase two pattern
   logic             p7;     // Reset gate pattern

   modport ctrl (output start, npix, input done, p5, p6, p7);
   modport gen  (input start, npix, output done, p5, p6, p7);
endinterface
`default_nettype wire

// ===== design/ccdr_hline.sv
/*
 * Horizontal line generator: produces the pixel patterns for one row.
 * Assumes start arrives only while no row is running.
 */
`timescale 1ns/10ps
`default_nettype none
module ccdr_hline
   import ccdr_pkg::*;
#(
   parameter int PIX_W = 11  // Width of the pixel counter
)(
   input  wire logic  clk,   // System clock
   input  wire logic  rstn,  // Synchronous reset, active low
   ccdr_hline_if.gen  hl     // Row request and patterns
);

   logic [PIX_W-1:0] pix_ff;   // Pixel index within the row
   logic [7:0]       ph_ff;    // Cycle within the pixel
   logic             busy_ff;  // Row in progress
   logic             done_ff;  // Row finished pulse

   wire last_ph = (ph_ff == 8'(PIX_CYC - 1));
   wire last_px = (pix_ff == hl.npix - PIX_W'(1));

   // Row and pixel counters
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pix_ff  <= '0;
         ph_ff   <= 8'h00;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (hl.start && !busy_ff) begin
            // Begin the row at pixel zero
            busy_ff <= 1'b1;
            pix_ff  <= '0;
            ph_ff   <= 8'h00;
         end else if (busy_ff && last_ph) begin
            ph_ff <= 8'h00;
            if (last_px) begin
               // Parking drops phase two: last pixel leaves
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               pix_ff <= pix_ff + PIX_W'(1);
            end
         end else if (busy_ff) begin
            ph_ff <= ph_ff + 8'h01;
         end
      end
   end

   // Patterns: phase one high first half, phase two second half
   assign hl.p5   = busy_ff ? (ph_ff < 8'(PIX_HALF)) : 1'b1;
   assign hl.p6   = busy_ff && (ph_ff >= 8'(PIX_HALF));
   assign hl.p7   = busy_ff && (ph_ff == 8'h00);
   assign hl.done = done_ff;

endmodule
`default_nettype wire

// ===== design/ccdr_ctrl.sv
/*
 * Frame sequencer driving an interline CCD: vertical phases, horizontal
 * phases of registers a-d, reset gates and the substrate shutter pulse.
 * Assumes external level shifters turn each code into pin voltages and
 * that the start, mode and exposure inputs come from logic on clk.
 */
`timescale 1ns/10ps
`default_nettype none
module ccdr_ctrl
   import ccdr_pkg::*;
#(
   parameter int LINE_W = 11,  // Width of the line counter
   parameter int PIX_W  = 11,  // Width of the pixel counter
   parameter int EXPO_W = 24   // Width of the exposure count
)(
   input  wire logic              clk,            // System clock
   input  wire logic              rstn,           // Synchronous reset, active low
   input  wire logic              frame_start,    // Pulse: begin a frame
   input  wire ccdr_mode_t        mode,           // Readout mode for next frame
   input  wire logic              shutter_en,     // Use the substrate shutter
   input  wire logic [EXPO_W-1:0] expo_cyc,       // Exposure in clock cycles
   input  wire logic              unused_clock,   // 1 clocks unused regs, 0 off
   output logic [3:0][1:0]        vert_top,       // Top phases 1-4 level codes
   output logic [3:0][1:0]        vert_bottom,    // Bottom phases 1-4 codes
   output logic [3:0]             horiz_phase1_storage,  // Registers a-d
   output logic [3:0]             horiz_phase1_barrier,  // Registers a-d
   output logic [3:0]             horiz_phase2_storage,  // Registers a-d
   output logic [3:0]             horiz_phase2_barrier,  // Registers a-d
   output logic [3:0]             horiz_last_phase,      // Registers a-d
   output logic [3:0]             reset_gate,     // Reset gates a-d
   output logic                   substrate_pulse, // Electronic shutter
   output logic                   busy,           // Frame in progress
   output logic                   frame_done      // Pulse: frame complete
);

   // Parameter checks at elaboration
   if (LINE_W < 11 || PIX_W < 11 || EXPO_W < 8) begin : g_chk
      $error("ccdr_ctrl: counter widths too small for the counts");
   end

   // Frame states, Gray coded along the usual path except ST_HREAD back to ST_VSTEP
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SHUT  = 3'h1,
      ST_EXPO  = 3'h3,
      ST_XFER  = 3'h2,
      ST_VSTEP = 3'h6,
      ST_HDLY  = 3'h7,
      ST_HREAD = 3'h5,
      ST_DONE  = 3'h4
   } ccdr_state_t;

   ccdr_state_t       st_ff;        // Frame state
   ccdr_mode_t        mode_ff;      // Mode latched for the frame
   logic              unclk_ff;     // Unused-register choice, latched
   logic              shut_ff;      // Shutter choice, latched
   logic [EXPO_W-1:0] expo_ff;      // Exposure latched
   logic [EXPO_W-1:0] cnt_ff;       // Timer for the current state
   logic [1:0]        vstep_ff;     // Vertical step index
   logic [LINE_W-1:0] line_ff;      // Lines read so far
   logic              hstart_ff;    // Row request pulse

   ccdr_hline_if #(.PIX_W(PIX_W)) hl ();  // Link to the line generator

   // Number of lines and pixels for the latched mode
   wire [LINE_W-1:0] nlines = full_height(mode_ff) ? LINE_W'(LINES_FULL)
                                                   : LINE_W'(LINES_HALF);
   wire [PIX_W-1:0]  npix   = full_width(mode_ff) ? PIX_W'(PIXS_FULL)
                                                  : PIX_W'(PIXS_HALF);
   wire              cnt_end = (cnt_ff == '0);

   assign hl.start = hstart_ff;
   assign hl.npix  = npix;

   ccdr_hline #(.PIX_W(PIX_W)) u_hline (
      .clk  (clk),
      .rstn (rstn),
      .hl   (hl)
   );

   // Frame sequencer
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_ff     <= ST_IDLE;
         mode_ff   <= CCDR_QUAD;
         unclk_ff  <= 1'b1;
         shut_ff   <= 1'b0;
         expo_ff   <= '0;
         cnt_ff    <= '0;
         vstep_ff  <= VSTEP_REST;
         line_ff   <= '0;
         hstart_ff <= 1'b0;
      end else begin
         hstart_ff <= 1'b0;
         cnt_ff    <= cnt_ff - EXPO_W'(1);  // Count down unless reloaded
         case (st_ff)
            ST_IDLE: begin
               if (frame_start) begin
                  // Mode, counts and mapping fixed for the whole frame
                  mode_ff  <= mode;
                  unclk_ff <= unused_clock;
                  shut_ff  <= shutter_en;
                  expo_ff  <= expo_cyc;
                  line_ff  <= '0;
                  if (shutter_en) begin
                     st_ff  <= ST_SHUT;
                     cnt_ff <= EXPO_W'(SUB_CYC - 1);
                  end else begin
                     st_ff  <= ST_XFER;
                     cnt_ff <= EXPO_W'(PD_CYC - 1);
                  end
               end
            end
            ST_SHUT: begin
               // Substrate pulse clears photodiodes, then integrate
               if (cnt_end) begin
                  st_ff  <= ST_EXPO;
                  cnt_ff <= expo_ff;
               end
            end
            ST_EXPO: begin
               if (cnt_end) begin
                  st_ff  <= ST_XFER;
                  cnt_ff <= EXPO_W'(PD_CYC - 1);
               end
            end
            ST_XFER: begin
               // Phase one at third level moves photodiode charge
               if (cnt_end) begin
                  st_ff    <= ST_VSTEP;
                  vstep_ff <= VSTEP_REST;
                  cnt_ff   <= EXPO_W'(VSTEP_CYC - 1);
               end
            end
            ST_VSTEP: begin
               // Four steps shift one line; phase one falls on the third
               if (cnt_end) begin
                  vstep_ff <= vstep_ff + 2'h1;
                  if (vstep_ff == 2'h2) begin
                     st_ff  <= ST_HDLY;
                     cnt_ff <= EXPO_W'(HDLY_CYC - 1);
                  end else begin
                     cnt_ff <= EXPO_W'(VSTEP_CYC - 1);
                  end
               end
            end
            ST_HDLY: begin
               if (cnt_end) begin
                  st_ff     <= ST_HREAD;
                  hstart_ff <= 1'b1;
               end
            end
            ST_HREAD: begin
               // Wait for the row; dummy row needs no extra line
               if (hl.done) begin
                  if (line_ff == nlines - LINE_W'(1)) begin
                     st_ff <= ST_DONE;
                  end else begin
                     st_ff   <= ST_VSTEP;
                     line_ff <= line_ff + LINE_W'(1);
                     cnt_ff  <= EXPO_W'(VSTEP_CYC - 1);
                  end
               end
            end
            ST_DONE: begin
               st_ff <= ST_IDLE;
            end
            default: begin
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Vertical level of phase k; neighbours high, one edge per change
   function automatic logic [1:0] vlevel(input int k, input logic [1:0] step,
                                         input logic pd);
      logic [1:0] kk;
      kk = 2'(k);
      if (pd) begin
         return (kk == 2'h0) ? CCDR_LVL_HIGH : CCDR_LVL_LOW;
      end
      return (kk == step || kk == step + 2'h1) ? CCDR_LVL_MID : CCDR_LVL_LOW;
   endfunction

   // Register b and d swap barriers when charge flows toward a or c
   function automatic logic swap_bar(input ccdr_mode_t m, input int r);
      return full_width(m) && (r == 1 || r == 3);
   endfunction

   // Whole register unused in this mode
   function automatic logic reg_idle(input ccdr_mode_t m, input int r);
      return (r >= 2) && full_height(m);
   endfunction

   // Reset gate unused in this mode
   function automatic logic rst_idle(input ccdr_mode_t m, input int r);
      return reg_idle(m, r) || swap_bar(m, r);
   endfunction

   // Vertical pin outputs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int k = 0; k < 4; k++) begin
            vert_top[k]    <= vlevel(k, VSTEP_REST, 1'b0);
            vert_bottom[k] <= vlevel(k, VSTEP_REST, 1'b0);
         end
      end else begin
         for (int k = 0; k < 4; k++) begin
            // All phases update on one edge, rise meets fall
            vert_bottom[k] <= vlevel(k, vstep_ff, st_ff == ST_XFER);
            if (full_height(mode_ff)) begin
               vert_top[k] <= vlevel((4 - k) % 4, vstep_ff,
                                     st_ff == ST_XFER);
            end else begin
               vert_top[k] <= vlevel(k, vstep_ff, st_ff == ST_XFER);
            end
         end
      end
   end

   // Horizontal and reset outputs per register a-d
   always_ff @(posedge clk) begin
      if (!rstn) begin
         horiz_phase1_storage <= 4'hF;
         horiz_phase1_barrier <= 4'hF;
         horiz_phase2_storage <= 4'h0;
         horiz_phase2_barrier <= 4'h0;
         horiz_last_phase     <= 4'h0;
         reset_gate           <= 4'h0;
      end else begin
         for (int r = 0; r < 4; r++) begin
            if (reg_idle(mode_ff, r) && !unclk_ff) begin
               // Off level holds the whole register
               horiz_phase1_storage[r] <= 1'b1;
               horiz_phase1_barrier[r] <= 1'b1;
               horiz_phase2_storage[r] <= 1'b1;
               horiz_phase2_barrier[r] <= 1'b1;
               horiz_last_phase[r]     <= 1'b1;
            end else begin
               horiz_phase1_storage[r] <= hl.p5;
               horiz_phase2_storage[r] <= hl.p6;
               horiz_last_phase[r]     <= hl.p6;
               if (swap_bar(mode_ff, r)) begin
                  horiz_phase1_barrier[r] <= hl.p6;
                  horiz_phase2_barrier[r] <= hl.p5;
               end else begin
                  horiz_phase1_barrier[r] <= hl.p5;
                  horiz_phase2_barrier[r] <= hl.p6;
               end
            end
            // Unused reset gate: off level or full clock
            if (rst_idle(mode_ff, r) && !unclk_ff) begin
               reset_gate[r] <= 1'b1;
            end else begin
               reset_gate[r] <= hl.p7;
            end
         end
      end
   end

   // Status and substrate outputs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         substrate_pulse <= 1'b0;
         busy            <= 1'b0;
         frame_done      <= 1'b0;
      end else begin
         substrate_pulse <= (st_ff == ST_SHUT) && shut_ff;
         busy            <= (st_ff != ST_IDLE);
         frame_done      <= (st_ff == ST_DONE);
      end
   end

endmodule
`default_nettype wire

// ===== verification/ccdr_ctrl_checker.sv
/* Assertions on the ports of the CCD clock-pattern controller.
   Assumes it is bound into ccdr_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module ccdr_ctrl_checker
   import ccdr_pkg::*;
(
   input wire logic            clk,                   // System clock
   input wire logic            rstn,                  // Reset, active low
   input wire logic            frame_start,           // Frame request
   input wire ccdr_mode_t      mode,                  // Readout mode
   input wire logic            unused_clock,          // Unused registers clocked
   input wire logic [3:0][1:0] vert_top,              // Top phase codes
   input wire logic [3:0][1:0] vert_bottom,           // Bottom phase codes
   input wire logic [3:0]      horiz_phase1_storage,  // Storage one, a-d
   input wire logic [3:0]      horiz_phase1_barrier,  // Barrier one, a-d
   input wire logic [3:0]      horiz_phase2_storage,  // Storage two, a-d
   input wire logic [3:0]      horiz_phase2_barrier,  // Barrier two, a-d
   input wire logic [3:0]      horiz_last_phase,      // Last phase, a-d
   input wire logic [3:0]      reset_gate,            // Reset gates, a-d
   input wire logic            substrate_pulse,       // Shutter pulse
   input wire logic            busy                   // Frame running
);
   ccdr_mode_t      mode_ff;     // Mode of running frame
   logic            unused_ff;   // Unused policy of running frame
   logic [3:0][1:0] prev_ff;     // Bottom codes one cycle ago
   logic [7:0]      pd_cnt_ff;   // Cycles at third level
   logic [7:0]      sub_cnt_ff;  // Cycles of shutter high
   logic            rise_any;    // Some phase rose
   logic            fall_any;    // Some phase fell

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Settings of the running frame
   always_ff @(posedge clk) begin
      if (frame_start && !busy) begin
         mode_ff   <= mode;
         unused_ff <= unused_clock;
      end
   end

   // History and pulse-width counters
   always_ff @(posedge clk) begin
      prev_ff    <= vert_bottom;
      pd_cnt_ff  <= (vert_bottom[0] == CCDR_LVL_HIGH) ? pd_cnt_ff + 8'h01 : 8'h00;
      sub_cnt_ff <= substrate_pulse ? sub_cnt_ff + 8'h01 : 8'h00;
   end

   // Direction of each vertical code change
   always_comb begin
      rise_any = 1'h0;
      fall_any = 1'h0;
      for (int k = 0; k < 4; k++) begin
         rise_any |= vert_bottom[k] > prev_ff[k];
         fall_any |= vert_bottom[k] < prev_ff[k];
      end
   end

   chk_last_copies_store: assert property (horiz_last_phase == horiz_phase2_storage)
      else $error("last phase not storage two");
   chk_top_direct_map: assert property (busy && mode_ff inside {CCDR_QUAD, CCDR_DUAL_AC}
      |-> vert_top == vert_bottom)
      else $error("top phases not mapped directly");
   chk_top_reverse_map: assert property (busy && mode_ff inside {CCDR_DUAL_AB, CCDR_SINGLE}
      |-> vert_top == {vert_bottom[1], vert_bottom[2], vert_bottom[3], vert_bottom[0]})
      else $error("top phases not reversed");
   chk_barrier_plain: assert property (busy && mode_ff inside {CCDR_QUAD, CCDR_DUAL_AB}
      |-> horiz_phase1_barrier == horiz_phase1_storage
      && horiz_phase2_barrier == horiz_phase2_storage)
      else $error("barrier differs from storage");
   chk_barrier_swapped: assert property (busy && mode_ff inside {CCDR_DUAL_AC, CCDR_SINGLE}
      |-> {horiz_phase1_barrier[3], horiz_phase1_barrier[1]}
      == {horiz_phase2_storage[3], horiz_phase2_storage[1]}
      && {horiz_phase2_barrier[3], horiz_phase2_barrier[1]}
      == {horiz_phase1_storage[3], horiz_phase1_storage[1]})
      else $error("b and d barriers not swapped");
   chk_unused_held_off: assert property (busy && !unused_ff
      && mode_ff inside {CCDR_DUAL_AB, CCDR_SINGLE}
      |-> &{reset_gate[3:2], horiz_phase1_storage[3:2], horiz_phase2_storage[3:2]})
      else $error("unused c and d not held off");
   chk_unused_clocked: assert property (busy && unused_ff
      |-> reset_gate == {4{reset_gate[0]}}
      && horiz_phase2_storage == {4{horiz_phase2_storage[0]}})
      else $error("unused registers not clocked");
   chk_rise_with_fall: assert property (rise_any |-> fall_any)
      else $error("vertical rise without a fall");
   chk_third_level_end: assert property ($fell(vert_bottom[0] == CCDR_LVL_HIGH)
      |-> vert_bottom[3] == CCDR_LVL_MID && pd_cnt_ff == 8'(PD_CYC))
      else $error("third level end misaligned");
   chk_shutter_width: assert property ($fell(substrate_pulse) |-> sub_cnt_ff == 8'(SUB_CYC))
      else $error("shutter pulse width wrong");
   chk_pixel_phase: assert property ($rose(horiz_last_phase[0])
      |-> (horiz_last_phase[0])[*3] ##1 !horiz_last_phase[0])
      else $error("last phase high time wrong");

   cover property (busy && mode_ff == CCDR_SINGLE);
   cover property ($fell(substrate_pulse));
   cover property (busy && mode_ff == CCDR_DUAL_AB && $rose(horiz_last_phase[0]));
endmodule

bind ccdr_ctrl ccdr_ctrl_checker u_chk (.clk(clk), .rstn(rstn), .frame_start(frame_start),
   .mode(mode), .unused_clock(unused_clock), .vert_top(vert_top), .vert_bottom(vert_bottom),
   .horiz_phase1_storage(horiz_phase1_storage), .horiz_phase1_barrier(horiz_phase1_barrier),
   .horiz_phase2_storage(horiz_phase2_storage), .horiz_phase2_barrier(horiz_phase2_barrier),
   .horiz_last_phase(horiz_last_phase), .reset_gate(reset_gate),
   .substrate_pulse(substrate_pulse), .busy(busy));
`default_nettype wire

// ===== verification/ccdr_dev_model.sv
/* Behavioural sensor: counts rows, pixels and exposure from pin edges.
   Assumes its pins are sampled on the controller clock. */
`timescale 1ns/10ps
`default_nettype none
module ccdr_dev_model
   import ccdr_pkg::*;
(
   input  wire logic            clk,          // Sampling clock
   input  wire logic            rstn,         // Clears the row count and the current pixel count
   input  wire logic [3:0][1:0] vert_bottom,  // Vertical phases
   input  wire logic            last_a,       // Last phase of register a
   input  wire logic            sub_pin,      // Substrate pin
   output logic [11:0]          rows_ff,      // Rows moved down
   output logic [11:0]          pix_last_ff,  // Pixels of previous row
   output logic [15:0]          integ_ff      // Last integration time
);
   logic [1:0]  v1_prev_ff;  // Phase one a cycle ago
   logic        last_pr_ff;  // Last phase a cycle ago
   logic        sub_pr_ff;   // Substrate a cycle ago
   logic [11:0] pix_ff;      // Pixels of current row
   logic [15:0] int_cnt_ff;  // Integration counter
   logic        int_on_ff;   // Integrating

   // Charge movement on pin edges
   always_ff @(posedge clk) begin
      v1_prev_ff <= vert_bottom[0];
      last_pr_ff <= last_a;
      sub_pr_ff  <= sub_pin;
      int_cnt_ff <= int_cnt_ff + 16'h0001;
      if (!rstn) begin
         rows_ff   <= 12'h000;
         pix_ff    <= 12'h000;
         int_on_ff <= 1'h0;
      end else begin
         // Phase one mid to low moves a row; dummy row merges
         if (v1_prev_ff == CCDR_LVL_MID && vert_bottom[0] == CCDR_LVL_LOW) begin
            rows_ff     <= rows_ff + 12'h001;
            pix_last_ff <= pix_ff;
            pix_ff      <= 12'h000;
         end else if (last_pr_ff && !last_a) begin
            pix_ff <= pix_ff + 12'h001;
         end
         // Shutter fall to third level end is exposure
         if (sub_pr_ff && !sub_pin) begin
            int_cnt_ff <= 16'h0001;
            int_on_ff  <= 1'h1;
         end else if (int_on_ff && v1_prev_ff == CCDR_LVL_HIGH
                      && vert_bottom[0] != CCDR_LVL_HIGH) begin
            integ_ff  <= int_cnt_ff;
            int_on_ff <= 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/ccd_readout_clock_patterns_tb_top.sv
/* Self-checking bench: one frame per table row, cut short by reset after two rows.
   Assumes the model and checker watch the same pins. */
`timescale 1ns/10ps
`default_nettype none
module ccd_readout_clock_patterns_tb_top import ccdr_pkg::*; ;

   typedef struct packed {
      ccdr_mode_t  mode;    // Readout mode
      logic        unused;  // Clock unused registers
      logic        shut;    // Use the shutter
      logic [11:0] npix;    // Pixels per row expected
   } ccdr_row_t;

   localparam int EXPO = 50;  // Exposure wait in cycles
   localparam ccdr_row_t ROWS [4] = '{
      '{CCDR_QUAD, 1'h1, 1'h0, 12'(PIXS_HALF)},
      '{CCDR_DUAL_AB, 1'h0, 1'h0, 12'(PIXS_HALF)},
      '{CCDR_DUAL_AC, 1'h0, 1'h0, 12'(PIXS_FULL)},
      '{CCDR_SINGLE, 1'h1, 1'h1, 12'(PIXS_FULL)}};

   logic            clk, rstn, frame_start, shutter_en, unused_clock;  // Inputs
   ccdr_mode_t      mode;                           // Mode input
   logic [23:0]     expo_cyc;                       // Exposure input
   logic [3:0][1:0] vert_top, vert_bottom;          // Vertical codes
   logic [3:0]      p1_store, p1_barr, p2_store;    // Horizontal phases
   logic [3:0]      p2_barr, last_ph, rgate;        // More pins
   logic            sub, busy, done;                // Status outputs
   logic [11:0]     rows, pix_last;                 // Model counts
   logic [15:0]     integ;                          // Model integration time
   int              n_mismatch, num_checks, cycles; // Tallies

   ccdr_ctrl u_dut (.clk(clk), .rstn(rstn), .frame_start(frame_start), .mode(mode),
      .shutter_en(shutter_en), .expo_cyc(expo_cyc), .unused_clock(unused_clock),
      .vert_top(vert_top), .vert_bottom(vert_bottom), .horiz_phase1_storage(p1_store),
      .horiz_phase1_barrier(p1_barr), .horiz_phase2_storage(p2_store),
      .horiz_phase2_barrier(p2_barr), .horiz_last_phase(last_ph), .reset_gate(rgate),
      .substrate_pulse(sub), .busy(busy), .frame_done(done));

   ccdr_dev_model u_dev (.clk(clk), .rstn(rstn), .vert_bottom(vert_bottom),
      .last_a(last_ph[0]), .sub_pin(sub), .rows_ff(rows), .pix_last_ff(pix_last),
      .integ_ff(integ));

   // Free-running clock
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // Compare one value and tally it
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Print counts and verdict, then stop
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Hold reset for ten cycles
   task automatic do_reset();
      rstn = 1'h0;
      repeat (10) @(negedge clk);
      rstn = 1'h1;
   endtask

   // One-cycle frame request
   task automatic start_frame(input ccdr_row_t r);
      mode = r.mode;
      unused_clock = r.unused;
      shutter_en = r.shut;
      frame_start = 1'h1;
      @(negedge clk);
      frame_start = 1'h0;
   endtask

   // Bounded wait for two rows
   task automatic wait_two_rows();
      for (int i = 0; i < 20000 && rows !== 12'h002; i++) @(negedge clk);
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         n_mismatch++;
         $display("CHECK FAILED run length expected below 90000 seen %0d", cycles);
         tally_and_finish();
      end
   end

   // Main sequence
   initial begin
      n_mismatch = 0;
      num_checks = 0;
      cycles = 0;
      frame_start = 1'h0;
      shutter_en = 1'h0;
      unused_clock = 1'h1;
      mode = CCDR_QUAD;
      expo_cyc = 24'(EXPO);
      do_reset();
      // Idle pin levels after reset
      check_val("bottom rest", 32'h41, {24'h0, vert_bottom});
      check_val("storage park", 32'hF0, {24'h0, p1_store, p2_store});
      check_val("idle status", 32'h0, {29'h0, busy, sub, done});
      // Each readout mode in turn
      foreach (ROWS[i]) begin
         do_reset();
         start_frame(ROWS[i]);
         wait_two_rows();
         check_val("rows moved", 32'h2, {20'h0, rows});
         check_val("pixels per row", {20'h0, ROWS[i].npix}, {20'h0, pix_last});
         if (ROWS[i].shut) begin
            check_val("integration", 32'(EXPO + 1 + PD_CYC), {16'h0, integ});
         end
      end
      // A request while busy is ignored
      do_reset();
      start_frame(ROWS[2]);
      repeat (20) @(negedge clk);
      start_frame(ROWS[0]);
      check_val("busy held", 32'h1, {31'h0, busy});
      wait_two_rows();
      check_val("pixels kept", {20'h0, ROWS[2].npix}, {20'h0, pix_last});
      tally_and_finish();
   end
endmodule
`default_nettype wire
